// *** rtl/issp_consts.svh ***
// Constants of the inertial sensor serial port: offsets, fields, resets, timing
`ifndef ISSP_CONSTS_SVH
`define ISSP_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define ISSP_CLK_HZ        100000000
// Rate in tenths of samples per second; scaled to stay inside 32 bits
`define ISSP_RATE_DSPS     8192
`define ISSP_SAMPLE_CYC    ((`ISSP_CLK_HZ / 64) * 10 / (`ISSP_RATE_DSPS / 64))
`define ISSP_FLASH_MS      50
`define ISSP_FLASH_CYC     (`ISSP_FLASH_MS * (`ISSP_CLK_HZ / 1000))
`define ISSP_DRDY_NS       1000
`define ISSP_DRDY_CYC      (`ISSP_DRDY_NS / (1000000000 / `ISSP_CLK_HZ))
`define ISSP_SCLK_HZ       1000000
`define ISSP_HALF_CYC      (`ISSP_CLK_HZ / (2 * `ISSP_SCLK_HZ))
`define ISSP_STALL_NS      9000
`define ISSP_STALL_CYC     (`ISSP_STALL_NS / (1000000000 / `ISSP_CLK_HZ))
`define ISSP_FRAME_BITS    16

// ----------------------------------------
// Register indices (byte address / 2) and fields
// ----------------------------------------
`define ISSP_IDX_FLASH_WRITE_COUNTER 5'h00
`define ISSP_IDX_OUT_FIRST 5'h01
`define ISSP_IDX_RSV_A     5'h03
`define ISSP_IDX_RSV_B     5'h04
`define ISSP_IDX_USR_FIRST 5'h0D
`define ISSP_IDX_RSV_C     5'h0E
`define ISSP_IDX_RSV_D     5'h0F
`define ISSP_IDX_USR_LAST  5'h1D
`define ISSP_IDX_GPIO      5'h19
`define ISSP_IDX_MSC       5'h1A
`define ISSP_IDX_SAMPLE_PERIOD_FIELD  5'h1B
`define ISSP_IDX_SENS_AVG  5'h1C
`define ISSP_ADDR_CMD      7'h3E
`define ISSP_CMD_FLASH_BIT 0
`define ISSP_GPIO4_DIR_BIT 3
`define ISSP_GPIO4_SYNC_BIT 7
`define ISSP_GPIO4_OUT_BIT 11
`define ISSP_GPIO4_IN_BIT  12
`define ISSP_RST_MSC       16'h0006
`define ISSP_RST_SAMPLE_PERIOD_FIELD  16'h0001
`define ISSP_RST_SENS_AVG  16'h0402

`endif

// *** rtl/issp_dev.sv ***
// Sensor end: serial slave, register file, sample timer, flash backup
`timescale 1ns/1ps
`include "issp_consts.svh"
module issp_dev #(
	parameter int SAMPLE_CYC = `ISSP_SAMPLE_CYC,
	parameter int FLASH_CYC  = `ISSP_FLASH_CYC
) (
	// Clock and reset
	input  wire logic                      CORE_CLK,
	input  wire logic                      RST,
	// Link
	issp_if.dev                            LINK,
	// Sensor data, indices 1 to 11
	input  wire issp_pkg::issp_word_t [10:0] SAMPLE_IN,
	// Status
	output logic                           SAMPLE_TAKEN,
	output logic                           FLASH_BUSY,
	output logic                           FLASH_STROBE
);
	import issp_pkg::*;

	typedef struct packed {
		logic                  cs_q;
		logic                  sclk_q;
		logic                  io4_q;
		logic [4:0]            bits;
		issp_word_t            rx;
		issp_word_t            tx;
		logic                  miso;
		logic [31:0]           base_cnt;
		logic [7:0]            prd_cnt;
		logic                  drdy;
		logic [15:0]           drdy_cnt;
		logic                  taken;
		logic                  io4_o;
		logic                  io4_oe;
		logic                  fl_busy;
		logic [31:0]           fl_cnt;
		logic                  fl_strobe;
		logic [31:0][15:0]     regs;
	} issp_dev_st_t;

	issp_dev_st_t st_r;
	issp_dev_st_t st_nxt;
	logic [3:0]   pins_s;
	logic         cs_s;
	logic         sclk_s;
	logic         mosi_s;
	logic         io4_s;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Idle: select high, clock high, data low, pin four pulled high
	issp_sync #(.W(4), .RST_VAL(4'hD)) u_sync (
		.clk (CORE_CLK),
		.rst (RST),
		.d   ({LINK.cs_n, LINK.sclk, LINK.mosi, LINK.gpio_or_sync_clock_pin}),
		.q   (pins_s)
	);
	assign {cs_s, sclk_s, mosi_s, io4_s} = pins_s;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic       tick;
		logic       sync_mode;
		logic [7:0] prd;
		logic [4:0] idx;
		logic [6:0] addr;
		issp_word_t rd;
		tick      = 1'b0;
		sync_mode = st_r.regs[`ISSP_IDX_GPIO][`ISSP_GPIO4_SYNC_BIT];
		prd       = st_r.regs[`ISSP_IDX_SAMPLE_PERIOD_FIELD][7:0];
		idx       = st_r.rx[13:9];
		addr      = st_r.rx[14:8];
		rd        = '0;
		st_nxt    = st_r;
		st_nxt.cs_q      = cs_s;
		st_nxt.sclk_q    = sclk_s;
		st_nxt.io4_q     = io4_s;
		st_nxt.taken     = 1'b0;
		st_nxt.fl_strobe = 1'b0;

		// Serial shifter, only while selected
		if (!cs_s && sclk_s && !st_r.sclk_q) begin
			st_nxt.rx = {st_r.rx[14:0], mosi_s};
			if (st_r.bits <= 5'd`ISSP_FRAME_BITS) begin
				st_nxt.bits = st_r.bits + 5'd1;
			end
		end
		if (!cs_s && !sclk_s && st_r.sclk_q) begin
			st_nxt.miso = st_r.tx[15];
			st_nxt.tx   = {st_r.tx[14:0], 1'b0};
		end
		if (!cs_s && st_r.cs_q) begin
			st_nxt.bits = '0;
		end

		// Frame end: act only on exactly sixteen bits
		if (cs_s && !st_r.cs_q) begin
			st_nxt.bits = '0;
			st_nxt.tx   = '0;
			st_nxt.miso = 1'b0;
			if (st_r.bits == 5'd`ISSP_FRAME_BITS) begin
				if (!st_r.rx[15]) begin
					// Both byte addresses of a register pick the same word
					rd = (addr[6]) ? 16'h0000 : st_r.regs[idx];
					if (idx == `ISSP_IDX_GPIO) begin
						rd[`ISSP_GPIO4_IN_BIT] = st_r.io4_q;
					end
					st_nxt.tx = rd;
				end else if ({1'b0, addr[5:0]} == `ISSP_ADDR_CMD) begin
					if (st_r.rx[`ISSP_CMD_FLASH_BIT] && !st_r.fl_busy) begin
						st_nxt.fl_busy = 1'b1;
						st_nxt.fl_cnt  = '0;
					end
				end else if (addr[5:1] >= `ISSP_IDX_USR_FIRST && addr[5:1] <= `ISSP_IDX_USR_LAST
					&& addr[5:1] != `ISSP_IDX_RSV_C && addr[5:1] != `ISSP_IDX_RSV_D) begin
					// Commit only here, never mid-shift
					if (addr[0]) begin
						st_nxt.regs[addr[5:1]][15:8] = st_r.rx[7:0];
					end else begin
						st_nxt.regs[addr[5:1]][7:0] = st_r.rx[7:0];
					end
				end
			end
		end

		// Sample pacing: internal timer or pin four edge
		if (sync_mode) begin
			tick = st_r.io4_q == 1'b0 && io4_s == 1'b1;
		end else if (st_r.base_cnt >= 32'(SAMPLE_CYC - 1)) begin
			st_nxt.base_cnt = '0;
			if (st_r.prd_cnt + 8'd1 >= prd) begin
				st_nxt.prd_cnt = '0;
				tick           = 1'b1;
			end else begin
				st_nxt.prd_cnt = st_r.prd_cnt + 8'd1;
			end
		end else begin
			st_nxt.base_cnt = st_r.base_cnt + 32'd1;
		end
		if (tick) begin
			for (int i = 0; i < 11; i++) begin
				if (5'(i + 1) != `ISSP_IDX_RSV_A && 5'(i + 1) != `ISSP_IDX_RSV_B) begin
					st_nxt.regs[5'(i + 1)] = SAMPLE_IN[i];
				end
			end
			st_nxt.taken    = 1'b1;
			st_nxt.drdy     = 1'b1;
			st_nxt.drdy_cnt = 16'(`ISSP_DRDY_CYC - 1);
		end else if (st_r.drdy_cnt != '0) begin
			st_nxt.drdy_cnt = st_r.drdy_cnt - 16'd1;
		end else begin
			st_nxt.drdy = 1'b0;
		end

		// Pin four as plain output unless pacing samples
		st_nxt.io4_oe = st_r.regs[`ISSP_IDX_GPIO][`ISSP_GPIO4_DIR_BIT] && !sync_mode;
		st_nxt.io4_o  = st_r.regs[`ISSP_IDX_GPIO][`ISSP_GPIO4_OUT_BIT];

		// Flash backup: count only a finished copy
		if (st_r.fl_busy) begin
			if (st_r.fl_cnt >= 32'(FLASH_CYC - 1)) begin
				st_nxt.fl_busy   = 1'b0;
				st_nxt.fl_strobe = 1'b1;
				st_nxt.regs[`ISSP_IDX_FLASH_WRITE_COUNTER] = st_r.regs[`ISSP_IDX_FLASH_WRITE_COUNTER] + 16'd1;
			end else begin
				st_nxt.fl_cnt = st_r.fl_cnt + 32'd1;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_r                             <= '0;
			st_r.cs_q                        <= 1'b1;
			st_r.sclk_q                      <= 1'b1;
			st_r.io4_q                       <= 1'b1;
			st_r.regs[`ISSP_IDX_MSC]         <= `ISSP_RST_MSC;
			st_r.regs[`ISSP_IDX_SAMPLE_PERIOD_FIELD]    <= `ISSP_RST_SAMPLE_PERIOD_FIELD;
			st_r.regs[`ISSP_IDX_SENS_AVG]    <= `ISSP_RST_SENS_AVG;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign LINK.miso           = st_r.miso;
	assign LINK.data_ready_pin = st_r.drdy;
	assign LINK.io4_dev_o      = st_r.io4_o;
	assign LINK.io4_dev_oe     = st_r.io4_oe;
	assign SAMPLE_TAKEN        = st_r.taken;
	assign FLASH_BUSY          = st_r.fl_busy;
	assign FLASH_STROBE        = st_r.fl_strobe;
endmodule

// *** rtl/issp_host.sv ***
// Master end: mode 3 frame engine, data-ready watcher, pin four drive
`timescale 1ns/1ps
`include "issp_consts.svh"
module issp_host (
	// Clock and reset
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST,
	// Link
	issp_if.host                      LINK,
	// Command
	input  wire logic                 CMD_VALID,
	input  wire issp_pkg::issp_word_t CMD_WORD,
	output logic                      CMD_READY,
	// Answer
	output logic                      RESP_VALID,
	output issp_pkg::issp_word_t      RESP_WORD,
	output logic                      DRDY_SEEN,
	// Pin four
	input  wire logic                 IO4_DRIVE,
	input  wire logic                 IO4_LEVEL
);
	import issp_pkg::*;

	typedef struct packed {
		issp_host_st_t st;
		logic [15:0]   div;
		logic [4:0]    bits;
		issp_word_t    tx;
		issp_word_t    rx;
		logic          cs_n;
		logic          sclk;
		logic          mosi;
		logic          resp_v;
		issp_word_t    resp;
		logic          drdy_q;
		logic          drdy_seen;
		logic          io4_o;
		logic          io4_oe;
	} issp_host_st2_t;

	issp_host_st2_t st_r;
	issp_host_st2_t st_nxt;
	logic [1:0]     pins_s;

	issp_sync #(.W(2)) u_sync (
		.clk (CORE_CLK),
		.rst (RST),
		.d   ({LINK.miso, LINK.data_ready_pin}),
		.q   (pins_s)
	);

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	always_comb begin
		logic half_done;
		half_done        = st_r.div == 16'(`ISSP_HALF_CYC - 1);
		st_nxt           = st_r;
		st_nxt.resp_v    = 1'b0;
		st_nxt.drdy_q    = pins_s[0];
		st_nxt.drdy_seen = pins_s[0] && !st_r.drdy_q;
		st_nxt.io4_o     = IO4_LEVEL;
		st_nxt.io4_oe    = IO4_DRIVE;
		st_nxt.div       = half_done ? 16'd0 : st_r.div + 16'd1;
		case (st_r.st)
			HS_IDLE: begin
				st_nxt.div = '0;
				if (CMD_VALID) begin
					st_nxt.tx   = CMD_WORD;
					st_nxt.cs_n = 1'b0;
					st_nxt.bits = '0;
					st_nxt.st   = HS_SETUP;
				end
			end
			HS_SETUP: begin
				if (half_done) begin
					st_nxt.sclk = 1'b0;
					st_nxt.mosi = st_r.tx[15];
					st_nxt.tx   = {st_r.tx[14:0], 1'b0};
					st_nxt.st   = HS_LOW;
				end
			end
			HS_LOW: begin
				if (half_done) begin
					// Capture on the rising edge, second edge of mode 3
					st_nxt.sclk = 1'b1;
					st_nxt.rx   = {st_r.rx[14:0], pins_s[1]};
					st_nxt.bits = st_r.bits + 5'd1;
					st_nxt.st   = HS_HIGH;
				end
			end
			HS_HIGH: begin
				if (half_done) begin
					if (st_r.bits == 5'd`ISSP_FRAME_BITS) begin
						st_nxt.cs_n   = 1'b1;
						st_nxt.resp_v = 1'b1;
						st_nxt.resp   = st_r.rx;
						st_nxt.st     = HS_STALL;
					end else begin
						st_nxt.sclk = 1'b0;
						st_nxt.mosi = st_r.tx[15];
						st_nxt.tx   = {st_r.tx[14:0], 1'b0};
						st_nxt.st   = HS_LOW;
					end
				end
			end
			HS_STALL: begin
				// Gap lets the slave reload its answer word
				// Own count: the half-period wrap never reaches the stall end
				st_nxt.div = st_r.div + 16'd1;
				if (st_r.div == 16'(`ISSP_STALL_CYC - 1)) begin
					st_nxt.div = '0;
					st_nxt.st  = HS_IDLE;
				end
			end
			default: begin
				st_nxt.st = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_r      <= '0;
			st_r.st   <= HS_IDLE;
			st_r.cs_n <= 1'b1;
			st_r.sclk <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Clock rate fixed at 1 MHz: inside normal and burst limits
	assign LINK.cs_n        = st_r.cs_n;
	assign LINK.sclk        = st_r.sclk;
	assign LINK.mosi        = st_r.mosi;
	assign LINK.io4_host_o  = st_r.io4_o;
	assign LINK.io4_host_oe = st_r.io4_oe;
	// Idle is bit zero of the one-hot state
	assign CMD_READY        = st_r.st[0];
	assign RESP_VALID       = st_r.resp_v;
	assign RESP_WORD        = st_r.resp;
	assign DRDY_SEEN        = st_r.drdy_seen;
endmodule

// *** rtl/issp_if.sv ***
// Link between sensor port and master: serial pins, data-ready, pin four
`timescale 1ns/1ps
interface issp_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic data_ready_pin;
	logic io4_dev_o;
	logic io4_dev_oe;
	logic io4_host_o;
	logic io4_host_oe;
	logic gpio_or_sync_clock_pin;

	// Pin four resolves to the sensor driver, else the master driver, pulled high when neither drives
	assign gpio_or_sync_clock_pin = io4_dev_oe ? io4_dev_o : (io4_host_oe ? io4_host_o : 1'b1);

	modport dev (
		input  cs_n, sclk, mosi, gpio_or_sync_clock_pin,
		output miso, data_ready_pin, io4_dev_o, io4_dev_oe
	);
	modport host (
		input  miso, data_ready_pin, gpio_or_sync_clock_pin,
		output cs_n, sclk, mosi, io4_host_o, io4_host_oe
	);
endinterface

// *** rtl/issp_pkg.sv ***
// Types shared by both ends of the inertial sensor serial port
package issp_pkg;
	typedef logic [15:0] issp_word_t;

	typedef enum logic [4:0] {
		HS_IDLE  = 5'h01,
		HS_SETUP = 5'h02,
		HS_LOW   = 5'h04,
		HS_HIGH  = 5'h08,
		HS_STALL = 5'h10
	} issp_host_st_t;
endpackage

// *** rtl/issp_sync.sv ***
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module issp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import issp_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} issp_sync_st_t;

	issp_sync_st_t st_r;
	issp_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// Idle level at reset, so no false edge follows release
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule

// *** tb/issp_props.sv ***
// Link checker: frame shape, clock timing, data-ready timing
`timescale 1ns/1ps
`include "issp_consts.svh"
module issp_props #(
	parameter int SAMPLE_CYC = 200
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic data_ready_pin,
	input wire logic gpio_or_sync_clock_pin
);
	// ----
	// Helper counters
	// ----
	logic [4:0]  bits_r;
	logic [7:0]  lo_r;
	logic [7:0]  hi_r;
	logic [31:0] gap_r;
	logic        seen_r;
	logic        sclk_q;
	logic        drdy_q;
	logic        io4_q;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bits_r <= 5'h00;
			lo_r <= 8'h00;
			hi_r <= 8'h00;
			gap_r <= 32'h0;
			seen_r <= 1'b0;
			sclk_q <= 1'b1;
			drdy_q <= 1'b0;
			io4_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
			drdy_q <= data_ready_pin;
			bits_r <= cs_n ? 5'h00 : bits_r + 5'(sclk & ~sclk_q);
			lo_r <= sclk ? 8'h00 : lo_r + 8'h01;
			hi_r <= data_ready_pin ? hi_r + 8'h01 : 8'h00;
			// First gap after reset is not a full period
			gap_r <= (data_ready_pin & ~drdy_q) ? 32'h1 : gap_r + 32'h1;
			io4_q <= gpio_or_sync_clock_pin;
			// Pin four may pace samples: restart the period check
			if (gpio_or_sync_clock_pin != io4_q) begin
				seen_r <= 1'b0;
			end else if (data_ready_pin & ~drdy_q) begin
				seen_r <= 1'b1;
			end
		end
	end
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_sclk_idle_high: assert property (cs_n |-> sclk)
		else $error("clock low while idle");
	a_cs_setup_gap: assert property ($fell(cs_n) |-> sclk [*8])
		else $error("clock moved too soon");
	a_half_period: assert property ($rose(sclk) && !cs_n |-> lo_r == 8'(`ISSP_HALF_CYC))
		else $error("clock low time wrong");
	a_frame_sixteen: assert property ($rose(cs_n) |-> bits_r == 5'h10)
		else $error("frame not 16 clocks");
	a_mosi_hold_high: assert property (sclk && $past(sclk) && !cs_n && !$past(cs_n)
		|-> $stable(mosi))
		else $error("host data moved at rise");
	a_miso_on_low: assert property ($changed(miso) && !cs_n |-> !$past(sclk, 2))
		else $error("device data moved off fall");
	a_miso_quiet: assert property (cs_n [*6] |-> !miso)
		else $error("device data while idle");
	a_ready_width: assert property ($fell(data_ready_pin) |-> hi_r == 8'(`ISSP_DRDY_CYC))
		else $error("ready pulse width wrong");
	a_sample_period: assert property ($rose(data_ready_pin) && seen_r
		|-> gap_r == 32'(SAMPLE_CYC))
		else $error("sample period wrong");
	c_frame: cover property ($rose(cs_n));
	c_ready: cover property ($fell(data_ready_pin));
	c_answer: cover property (!cs_n && miso);
	c_sync: cover property ($rose(gpio_or_sync_clock_pin) ##[1:8] $rose(data_ready_pin));
endmodule

// *** tb/testbench.sv ***
// Bench joining both ends: commands in, answers scored off a queue
`timescale 1ns/1ps
module testbench;
	import issp_pkg::*;
	localparam int SAMPLE_CYC = 200;
	// ----
	// Signals
	// ----
	logic              core_clk;
	logic              rst;
	logic              cmd_valid;
	issp_word_t        cmd_word;
	logic              cmd_ready;
	logic              resp_valid;
	issp_word_t        resp_word;
	logic              io4_drive;
	logic              io4_level;
	issp_word_t [10:0] sample_in;
	logic              sample_taken;
	logic              flash_busy;
	logic              flash_strobe;
	int                mismatches;
	int                comparisons;
	int                strobes;
	int                n;
	logic [16:0]       exp_q[$];
	logic [16:0]       pend;
	logic [16:0]       e;
	issp_word_t        v;
	issp_if issp_if_i ();
	issp_dev #(.SAMPLE_CYC(SAMPLE_CYC), .FLASH_CYC(3000)) issp_dev_i (.CORE_CLK(core_clk),
		.RST(rst), .LINK(issp_if_i), .SAMPLE_IN(sample_in), .SAMPLE_TAKEN(sample_taken),
		.FLASH_BUSY(flash_busy), .FLASH_STROBE(flash_strobe));
	issp_host issp_host_i (.CORE_CLK(core_clk), .RST(rst), .LINK(issp_if_i),
		.CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CMD_READY(cmd_ready),
		.RESP_VALID(resp_valid), .RESP_WORD(resp_word), .DRDY_SEEN(),
		.IO4_DRIVE(io4_drive), .IO4_LEVEL(io4_level));
	issp_props #(.SAMPLE_CYC(SAMPLE_CYC)) issp_props_i (.CORE_CLK(core_clk), .RST(rst),
		.cs_n(issp_if_i.cs_n), .sclk(issp_if_i.sclk), .mosi(issp_if_i.mosi),
		.miso(issp_if_i.miso), .data_ready_pin(issp_if_i.data_ready_pin),
		.gpio_or_sync_clock_pin(issp_if_i.gpio_or_sync_clock_pin));
	// ----
	// Tasks
	// ----
	task automatic chk(input issp_word_t seen, input issp_word_t want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic timed_out();
		mismatches++;
		$display("BAD %0t wait ran out", $time);
		report_and_stop();
	endtask
	// Answer of this frame belongs to the previous request
	task automatic send(input issp_word_t w, input logic nchk, input issp_word_t nv);
		int k;
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
			if (k > 4000) timed_out();
		end while (cmd_ready !== 1'b1);
		exp_q.push_back(pend);
		pend = {nchk, nv};
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_word <= w;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic drain();
		send(16'h0000, 1'b0, 16'h0000);
		n = 0;
		while (exp_q.size() > 0) begin
			@(negedge core_clk);
			n++;
			if (n > 4000) timed_out();
		end
	endtask
	// ----
	// Clock, monitor, sequence
	// ----
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (resp_valid === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[16]) chk(resp_word, e[15:0]);
		end
		if (flash_strobe === 1'b1) strobes++;
	end
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
		io4_drive = 1'b0;
		io4_level = 1'b0;
		mismatches = 0;
		comparisons = 0;
		strobes = 0;
		pend = 17'h00000;
		v = 16'($urandom(62892));
		for (int i = 0; i < 11; i++) sample_in[i] = 16'($urandom());
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		send(16'h3400, 1'b1, 16'h0006);
		send(16'h3700, 1'b1, 16'h0001);
		send(16'h3800, 1'b1, 16'h0402);
		send(16'h4000, 1'b1, 16'h0000);
		send(16'h0000, 1'b1, 16'h0000);
		drain();
		$display("test defaults done");
		v = 16'($urandom());
		send({8'h9A, v[7:0]}, 1'b0, 16'h0000);
		send({8'h9B, v[15:8]}, 1'b0, 16'h0000);
		send(16'hBC55, 1'b0, 16'h0000);
		send(16'h1A00, 1'b1, v);
		send(16'h3C00, 1'b1, 16'h0000);
		drain();
		$display("test writes done");
		@(posedge core_clk);
		for (int i = 0; i < 11; i++) sample_in[i] <= 16'($urandom());
		// Two loads so the new inputs are surely captured
		repeat (2) begin
			n = 0;
			do begin
				@(negedge core_clk);
				n++;
				if (n > 1000) timed_out();
			end while (sample_taken !== 1'b1);
		end
		for (int i = 1; i < 12; i++) begin
			if (i != 3 && i != 4) send({1'b0, 6'(i), 9'h000}, 1'b1, sample_in[i-1]);
		end
		drain();
		$display("test samples done");
		send(16'hBE01, 1'b0, 16'h0000);
		send(16'hBE01, 1'b0, 16'h0000);
		@(negedge core_clk);
		chk({15'h0000, flash_busy}, 16'h0001);
		n = 0;
		while (flash_busy !== 1'b0) begin
			@(negedge core_clk);
			n++;
			if (n > 10000) timed_out();
		end
		@(posedge core_clk);
		chk(16'(strobes), 16'h0001);
		send(16'h0100, 1'b1, 16'h0001);
		drain();
		$display("test backup done");
		@(posedge core_clk);
		io4_drive <= 1'b1;
		io4_level <= v[0];
		send(16'h3200, 1'b1, {3'h0, v[0], 12'h000});
		drain();
		@(posedge core_clk);
		io4_drive <= 1'b0;
		send(16'hB208, 1'b0, 16'h0000);
		send(16'hB308, 1'b0, 16'h0000);
		send(16'h3200, 1'b1, 16'h1808);
		drain();
		chk({15'h0000, issp_if_i.gpio_or_sync_clock_pin}, 16'h0001);
		// Low level proves the sensor drives; the pull-up alone reads high
		send(16'hB300, 1'b0, 16'h0000);
		send(16'h3200, 1'b1, 16'h0008);
		@(negedge core_clk);
		chk({15'h0000, issp_if_i.gpio_or_sync_clock_pin}, 16'h0000);
		$display("test pin four done");
		// Host holds pin four low before the sensor lets go of it
		@(posedge core_clk);
		io4_drive <= 1'b1;
		io4_level <= 1'b0;
		send(16'hB280, 1'b0, 16'h0000);
		drain();
		n = 0;
		repeat (400) begin
			@(negedge core_clk);
			if (sample_taken === 1'b1) n++;
		end
		chk(16'(n), 16'h0000);
		@(posedge core_clk);
		io4_level <= 1'b1;
		n = 0;
		repeat (20) begin
			@(negedge core_clk);
			if (sample_taken === 1'b1) n++;
		end
		chk(16'(n), 16'h0001);
		$display("test sync clock done");
		report_and_stop();
	end
endmodule
